// ==== hw/rps_register_page_stack.sv ====
// Page select register with an automatic page stack for interrupts.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Interrupt entry pushes current page when enabled.
// RULE_02 - Entry loads interrupting peripheral page as active.
// RULE_03 - Software page writes take effect unless an entry or return acts in the same cycle.
// RULE_04 - Control bit 0 enables automatic paging.
// RULE_05 - Control bits 7:1 read zero, writes ignored.
// RULE_06 - Control decoded at 0x84 on page 0x0F.
// RULE_07 - Return from interrupt pops the saved page.
module rps_register_page_stack (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire rps_pkg::rps_bus_t bus,
    input wire rps_pkg::rps_irq_t irq,
    output logic [7:0] rdata,
    output logic rhit,
    output logic [7:0] active_page_select,
    output logic auto_page_enable
);

    // The stack holds three levels: the active page and two saved pages.
    // A third nested entry pushes the oldest saved page off the bottom,
    // so that page cannot be recovered by later returns.
    // A return with nothing saved selects page 0x00.
    // Entries and returns are ignored while automatic paging is off,
    // so software that turns it off inside a routine must restore the
    // page itself before it returns.
    // The active page and the next saved level are visible on every
    // page; the control register only while the configuration page is
    // selected.

    // Level 0 is the active page and the top of the stack.
    logic [7:0] page_r [rps_pkg::STACK_DEPTH];
    logic [1:0] depth_r;
    logic [7:0] rdata_nxt;

    logic on_config_page;
    logic ctrl_sel;
    logic page_sel;
    logic next_sel;
    logic any_sel;

    logic ctrl_wr;
    logic page_wr;
    logic next_wr;

    logic do_push;
    logic do_pop;
    logic stack_empty;
    logic stack_full;

    // On any other page the address of the control register belongs to
    // another block, so neither reads nor writes may reach it there.
    assign on_config_page = page_r[0] == rps_pkg::CONFIG_PAGE;
    assign ctrl_sel = (bus.addr == rps_pkg::PAGE_CONTROL_ADDR) &&
                      on_config_page; // RULE_06
    assign page_sel = bus.addr == rps_pkg::ACTIVE_PAGE_ADDR;
    assign next_sel = bus.addr == rps_pkg::PAGE_STACK_ADDR;
    assign any_sel = ctrl_sel || page_sel || next_sel;

    assign ctrl_wr = bus.wr && ctrl_sel;
    assign page_wr = bus.wr && page_sel;
    assign next_wr = bus.wr && next_sel;

    // An entry beats a return in the same cycle, and both beat a bus
    // write to a page level, so the stack never mixes two updates.
    assign do_push = irq.entry && auto_page_enable; // RULE_04
    assign do_pop = irq.ret && auto_page_enable &&
                    !irq.entry; // RULE_07

    assign stack_empty = depth_r == 2'h0;
    assign stack_full = depth_r == rps_pkg::DEPTH_MAX;

    assign active_page_select = page_r[0];

    // Only the enable bit has storage; bits 7:1 are never kept.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            auto_page_enable <=
                rps_pkg::PAGE_CONTROL_RESET[rps_pkg::AUTO_EN_BIT]; // RULE_06
        end else if (ctrl_wr) begin
            auto_page_enable <= bus.wdata[rps_pkg::AUTO_EN_BIT]; // RULE_05
        end
    end

    generate
        for (genvar i = 0; i < rps_pkg::STACK_DEPTH; i++) begin : g_lvl
            if (i == 0) begin : g_top
                // The active page takes the peripheral's page on entry
                // and the saved page on return.
                always_ff @(posedge sys_clk) begin
                    if (!nrst) begin
                        page_r[i] <= rps_pkg::ACTIVE_PAGE_RESET;
                    end else if (do_push) begin
                        page_r[i] <= irq.page; // RULE_02
                    end else if (do_pop && stack_empty) begin
                        page_r[i] <= rps_pkg::ACTIVE_PAGE_RESET;
                    end else if (do_pop) begin
                        page_r[i] <= page_r[i+1]; // RULE_07
                    end else if (page_wr) begin
                        page_r[i] <= bus.wdata; // RULE_03
                    end
                end

            end else if (i == rps_pkg::STACK_DEPTH - 1) begin : g_bottom
                // The deepest level loses its page when a push overflows.
                always_ff @(posedge sys_clk) begin
                    if (!nrst) begin
                        page_r[i] <= rps_pkg::ACTIVE_PAGE_RESET;
                    end else if (do_push) begin
                        page_r[i] <= page_r[i-1]; // RULE_01
                    end else if (do_pop) begin
                        page_r[i] <= rps_pkg::ACTIVE_PAGE_RESET;
                    end
                end

            end else begin : g_mid
                // Only the level just below the top is on the bus.
                always_ff @(posedge sys_clk) begin
                    if (!nrst) begin
                        page_r[i] <= rps_pkg::ACTIVE_PAGE_RESET;
                    end else if (do_push) begin
                        page_r[i] <= page_r[i-1]; // RULE_01
                    end else if (do_pop) begin
                        page_r[i] <= page_r[i+1]; // RULE_07
                    end else if (next_wr && i == 1) begin
                        page_r[i] <= bus.wdata;
                    end
                end
            end
        end
    endgenerate

    // Nesting depth saturates at the number of saved levels, which
    // matches the page that an overflowing push throws away.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            depth_r <= 2'h0;
        end else if (do_push && !stack_full) begin
            depth_r <= depth_r + 2'h1;
        end else if (do_pop && !stack_empty) begin
            depth_r <= depth_r - 2'h1;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (ctrl_sel) begin
            rdata_nxt = {7'h00, auto_page_enable}; // RULE_05
        end else if (page_sel) begin
            rdata_nxt = page_r[0];
        end else if (next_sel) begin
            rdata_nxt = page_r[1];
        end
    end

    // Read data stands for the one cycle after the strobe and is zero
    // otherwise, so a bus that ORs several blocks needs no other mux.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= 8'h00;
        end
    end

    // The hit flag tells the core that this block answered the read.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rhit <= 1'b0;
        end else if (bus.rd) begin
            rhit <= any_sel;
        end else begin
            rhit <= 1'b0;
        end
    end

endmodule : rps_register_page_stack

// ==== common/rps_pkg.sv ====
// Package for the register page stack: addresses, fields, resets, types.
package rps_pkg;
    localparam logic [7:0] PAGE_CONTROL_ADDR = 8'h84;
    localparam logic [7:0] PAGE_STACK_ADDR = 8'h85;
    localparam logic [7:0] ACTIVE_PAGE_ADDR = 8'ha7;
    localparam logic [7:0] CONFIG_PAGE = 8'h0f;
    localparam logic [7:0] CAN_PAGE = 8'h0c;
    localparam int AUTO_EN_BIT = 0;
    localparam logic [7:0] PAGE_CONTROL_RESET = 8'h01;
    localparam logic [7:0] ACTIVE_PAGE_RESET = 8'h00;
    localparam int STACK_DEPTH = 3;
    localparam logic [1:0] DEPTH_MAX = 2'h2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rps_bus_t;

    typedef struct packed {
        logic entry;
        logic ret;
        logic [7:0] page;
    } rps_irq_t;
endpackage : rps_pkg

// ==== sim/rps_core_model.sv ====
// Core model that vectors to and returns from interrupt routines.
`timescale 1ns/1ps
module rps_core_model (
    input wire logic sys_clk,
    output rps_pkg::rps_irq_t irq
);
    initial irq = '0;
    task vector(input logic [7:0] p);
        @(negedge sys_clk) irq <= '{1'b1, 1'b0, p};
        @(negedge sys_clk) irq <= '{1'b0, 1'b0, ~p};
    endtask : vector
    task vector_reti(input logic [7:0] p);
        @(negedge sys_clk) irq <= '{1'b1, 1'b0, p};
        @(negedge sys_clk) irq <= '{1'b0, 1'b1, ~p};
        @(negedge sys_clk) irq <= '{1'b0, 1'b0, p};
    endtask : vector_reti
    task reti;
        @(negedge sys_clk) irq <= '{1'b0, 1'b1, 8'h5a};
        @(negedge sys_clk) irq <= '{1'b0, 1'b0, 8'ha5};
    endtask : reti
endmodule : rps_core_model

// ==== sim/rps_checker.sv ====
// Checker for the register page stack ports.
`timescale 1ns/1ps
module rps_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire rps_pkg::rps_bus_t bus,
    input wire rps_pkg::rps_irq_t irq,
    input wire logic [7:0] rdata,
    input wire logic rhit,
    input wire logic [7:0] active_page_select,
    input wire logic auto_page_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic ent;
    logic page_addr;
    logic ctrl_addr;
    logic cfg_page;
    assign ent = irq.entry && auto_page_enable;
    assign page_addr = bus.addr == rps_pkg::ACTIVE_PAGE_ADDR;
    assign ctrl_addr = bus.addr == rps_pkg::PAGE_CONTROL_ADDR;
    assign cfg_page = active_page_select == rps_pkg::CONFIG_PAGE;
    rst_val_a: assert property (
        $rose(nrst) |-> auto_page_enable)
        else $error("enable not set after reset");
    entry_load_a: assert property (
        ent |=> active_page_select == $past(irq.page))
        else $error("entry page not loaded");
    sw_page_a: assert property (
        bus.wr && page_addr && !irq.entry && !irq.ret
        |=> active_page_select == $past(bus.wdata))
        else $error("page write lost");
    no_auto_a: assert property (
        irq.entry && !auto_page_enable && !bus.wr
        |=> $stable(active_page_select))
        else $error("page changed with paging off");
    ctl_read_a: assert property (
        bus.rd && ctrl_addr && cfg_page
        |=> rhit && rdata == {7'h00, $past(auto_page_enable)})
        else $error("bad control read");
    ctl_off_a: assert property (
        bus.wr && ctrl_addr && !cfg_page |=> $stable(auto_page_enable))
        else $error("control written off page");
    pop_back_a: assert property (
        ent && !bus.wr ##1 irq.ret && !irq.entry && auto_page_enable
        && !bus.wr |=> active_page_select == $past(active_page_select, 2))
        else $error("saved page not restored");
    cover property (ent);
    cover property (irq.ret && auto_page_enable);
    cover property (rhit);
    cover property (irq.entry && !auto_page_enable);
endmodule : rps_checker
bind rps_register_page_stack rps_checker i_chk (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .bus(bus),
    .irq(irq),
    .rdata(rdata),
    .rhit(rhit),
    .active_page_select(active_page_select),
    .auto_page_enable(auto_page_enable)
);

// ==== sim/rps_register_page_stack_test.sv ====
// Testbench for the register page stack.
`timescale 1ns/1ps
module rps_register_page_stack_test;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic rhit;
    logic auto_page_enable;
    logic [7:0] rdata;
    logic [7:0] active_page_select;
    rps_pkg::rps_bus_t bus = '0;
    rps_pkg::rps_irq_t irq;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    always #50 sys_clk = ~sys_clk;
    rps_register_page_stack i_dut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .bus(bus),
        .irq(irq),
        .rdata(rdata),
        .rhit(rhit),
        .active_page_select(active_page_select),
        .auto_page_enable(auto_page_enable)
    );
    rps_core_model i_core (
        .sys_clk(sys_clk),
        .irq(irq)
    );
    task check(input string nm, input logic [8:0] seen,
               input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk) bus <= '{1'b1, 1'b0, a, d};
        @(negedge sys_clk) bus <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    // Read data is registered, so it is taken one cycle after the strobe.
    task rd(input logic [7:0] a, output logic [8:0] v);
        @(negedge sys_clk) bus <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge sys_clk) bus <= '0;
        v = {rhit, rdata};
    endtask : rd
    task t_reset;
        logic [8:0] v;
        rd(8'ha7, v);
        check("page", v, 9'h100);
        rd(8'h84, v);
        check("ctl_off_page", v, 9'h000);
        check("enable_out", {8'h00, auto_page_enable}, 9'h001);
        $display("test reset done");
    endtask : t_reset
    task t_control;
        logic [8:0] v;
        wr(8'ha7, 8'h0f);
        rd(8'h84, v);
        check("ctl", v, 9'h101);
        wr(8'h84, 8'hfe);
        rd(8'h84, v);
        check("ctl", v, 9'h100);
        check("enable_out", {8'h00, auto_page_enable}, 9'h000);
        $display("test control done");
    endtask : t_control
    task t_no_auto;
        logic [8:0] v;
        i_core.vector(8'h0c);
        rd(8'ha7, v);
        check("page", v, 9'h10f);
        check("page_out", {1'b0, active_page_select}, 9'h00f);
        $display("test no auto done");
    endtask : t_no_auto
    task t_nest;
        logic [8:0] v;
        wr(8'h84, 8'h01);
        wr(8'ha7, 8'h03);
        i_core.vector(8'h0c);
        rd(8'h85, v);
        check("next", v, 9'h103);
        rd(8'ha7, v);
        check("page", v, 9'h10c);
        wr(8'ha7, 8'h05);
        rd(8'ha7, v);
        check("page", v, 9'h105);
        check("page_out", {1'b0, active_page_select}, 9'h005);
        i_core.reti;
        rd(8'ha7, v);
        check("page", v, 9'h103);
        i_core.vector_reti(8'h0c);
        rd(8'ha7, v);
        check("page", v, 9'h103);
        $display("test nest done");
    endtask : t_nest
    task t_mid_reset;
        logic [8:0] v;
        wr(8'h85, 8'h07);
        @(negedge sys_clk) nrst <= 1'b0;
        repeat (2) @(negedge sys_clk);
        nrst <= 1'b1;
        rd(8'h85, v);
        check("next", v, 9'h100);
        rd(8'ha7, v);
        check("page", v, 9'h100);
        check("enable_out", {8'h00, auto_page_enable}, 9'h001);
        $display("test mid reset done");
    endtask : t_mid_reset
    task results;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    always @(posedge sys_clk) if (++cyc == 3000) begin
        n_mismatch++;
        results;
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        nrst <= 1'b1;
        t_reset;
        t_control;
        t_no_auto;
        t_nest;
        t_mid_reset;
        results;
    end
endmodule : rps_register_page_stack_test
